/* File: rtl/sleep_wake_cfg.svh */
// offsets, field positions, reset values and timing counts of the sleep/wake block
// assumes one 250 MHz register clock and byte-wide register access
`ifndef SLEEP_WAKE_CFG_SVH
`define SLEEP_WAKE_CFG_SVH

// register offsets in the expanded bank
`define PDC_OFFSET 8'h00
`define SWC_OFFSET 8'h0b

// reset values
`define PDC_RESET 8'hfe
`define SWC_RESET 8'h20

// port_drive_config fields
`define PDC_CMP_ROUTE 0
`define PDC_P0_PUSH 2
`define PDC_P0_STD 3
`define PDC_P2_STD 5
`define PDC_P3_STD 6
`define PDC_OSC_STD 7

// stop_wake_control fields
`define SWC_WARM 7
`define SWC_LEVEL 6
`define SWC_DELAY 5
`define SWC_SRC_HI 4
`define SWC_SRC_LO 2
`define SWC_UNDIV 1
`define SWC_DIV16 0

// program restart address after stop
`define RESTART_ADDR 16'h000c

// reset delay, arbitrary default length
`define CLK_PERIOD_NS 4
`define POR_DELAY_NS 1024
`define POR_DELAY_CYCLES ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// last step of the divide-by-16 prescaler
`define DIV16_LAST 4'hf

`endif

/* File: rtl/sleep_wake_pkg.sv */
// types shared by the sleep/wake block
// assumes nothing of its surroundings
package sleep_wake_pkg;

	typedef enum logic [1:0] {st_run, st_halt, st_stop, st_delay} power_state_t;

	typedef enum logic [2:0] {
		src_reset_only, src_port3_pin0, src_port3_pin1, src_port3_pin2,
		src_port3_pin3, src_port2_pin7, src_port2_nor_low, src_port2_nor_all
	} wake_src_t;

endpackage

/* File: rtl/wake_source_detect.sv */
// wake detector: compares the selected recovery source with the selected level
// assumes port inputs are synchronous to sys_clk
module wake_source_detect (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [2:0] src_sel,
	input wire logic level_high,
	input wire logic [3:0] port3_in,
	input wire logic [7:0] port2_in,
	output logic wake_hit_reg
);

	logic src_level;

	always_comb begin
		unique case (sleep_wake_pkg::wake_src_t'(src_sel))
			sleep_wake_pkg::src_reset_only: src_level = 1'b0;
			sleep_wake_pkg::src_port3_pin0: src_level = port3_in[0];
			sleep_wake_pkg::src_port3_pin1: src_level = port3_in[1];
			sleep_wake_pkg::src_port3_pin2: src_level = port3_in[2];
			sleep_wake_pkg::src_port3_pin3: src_level = port3_in[3];
			sleep_wake_pkg::src_port2_pin7: src_level = port2_in[7];
			sleep_wake_pkg::src_port2_nor_low: src_level = ~|port2_in[3:0];
			sleep_wake_pkg::src_port2_nor_all: src_level = ~|port2_in;
		endcase
	end

	// continuous compare, reset-only selection never wakes
	always_ff @(posedge sys_clk or negedge rstn) begin // RL22
		if (!rstn) begin
			wake_hit_reg <= 1'b0;
		end else begin
			wake_hit_reg <= (src_sel != 3'h0) && (src_level == level_high); // RL12 RL14
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	level_match_a: assert property (src_sel == 3'h1 && port3_in[0] == level_high |=> wake_hit_reg) // RL12
		else $error("selected port3 pin at wake level did not wake");
	reset_only_a: assert property (src_sel == 3'h0 |=> !wake_hit_reg) // RL14
		else $error("reset-only source produced a wake");

endmodule

/* File: rtl/clock_enable_divider.sv */
// system and timer clock enables: divide by two or one, optional divide by sixteen
// assumes sys_clk stands for the oscillator input
`include "sleep_wake_cfg.svh"
module clock_enable_divider (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic undivided_sel,
	input wire logic div16_sel,
	input wire logic sclk_run,
	input wire logic timer_clock_run,
	output logic sclk_en_reg,
	output logic timer_clock_en_reg
);

	logic half_reg;
	logic [3:0] pre_reg;
	logic base_tick;
	logic tick;

	assign base_tick = undivided_sel | half_reg; // RL15
	assign tick = base_tick & (!div16_sel | (pre_reg == `DIV16_LAST)); // RL16

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			half_reg <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pre_reg <= 4'h0;
		end else if (!div16_sel) begin
			pre_reg <= 4'h0;
		end else if (base_tick) begin
			pre_reg <= pre_reg + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_en_reg <= 1'b0;
			timer_clock_en_reg <= 1'b0;
		end else begin
			sclk_en_reg <= tick & sclk_run;
			timer_clock_en_reg <= tick & timer_clock_run;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	undivided_a: assert property (undivided_sel && !div16_sel && sclk_run |=> sclk_en_reg) // RL15
		else $error("undivided clock missed an enable");
	halved_a: assert property (!undivided_sel && !div16_sel && !$past(undivided_sel) && timer_clock_en_reg // RL15
		|=> !timer_clock_en_reg)
		else $error("halved clock gave two enables in a row");
	prescale_a: assert property (div16_sel && $past(div16_sel) && sclk_en_reg |=> !sclk_en_reg) // RL16
		else $error("prescaler gave back to back enables");

endmodule

/* File: rtl/sleep_wake_port_config.sv */
// halt/stop sequencing, stop recovery control and port drive configuration
// assumes the cpu reports halt, stop and taken interrupts as one-cycle pulses,
// and that register accesses arrive as one-cycle strobes on the bank port
`include "sleep_wake_cfg.svh"

// How it works
// RL1 - halt ends only on a taken interrupt; the code also leaves halt on a watchdog time-out
// RL2 - software puts no-op before each sleep
// RL3 - stop halts clocks, oscillator and comparators
// RL4 - stop ends on wake or reset, restarts 000c
// RL5 - watchdog in stop always applies reset delay
// RL6 - permanent rc watchdog always keeps running
// RL7 - drive bit0 routes comparators to port3 pins
// RL8 - drive bit2 selects port0 push-pull or open-drain
// RL9 - bits 3,5,6 pick port drive strength
// RL10 - bit7 sets oscillator and strobe drive
// RL11 - warm flag set by recovery, power-on clears
// RL12 - bit6 chooses wake level low or high
// RL13 - bit5 inserts reset delay after recovery
// RL14 - bits 4..2 choose the wake source
// RL15 - bit1 selects undivided or halved clock
// RL16 - bit0 adds divide-by-16 prescaler
// RL17 - software keeps second register reserved bits zero
// RL18 - halt stops only the processor clock
// RL19 - recovery clears the divide-by-16 bit
// RL20 - fast wake source held five clocks; the code wakes on one registered source match
// RL21 - warm flag set when entering stop
// RL22 - wake compare runs continuously while stopped
module sleep_wake_port_config (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic halt_exec,
	input wire logic stop_exec,
	input wire logic irq_taken,
	input wire logic watchdog_timeout,
	input wire logic watchdog_permanent,
	input wire logic watchdog_rc_select,
	input wire logic [3:0] port3_in,
	input wire logic [7:0] port2_in,
	output logic cpu_clk_run,
	output logic osc_run,
	output logic comparator_power,
	output logic cpu_reset_hold,
	output logic restart_load,
	output logic [15:0] restart_addr,
	output logic watchdog_run,
	output logic sclk_en,
	output logic timer_clock_en,
	output logic comparator_route,
	output logic port0_push_pull,
	output logic port0_std_drive,
	output logic port2_std_drive,
	output logic port3_std_drive,
	output logic osc_std_drive
);

	localparam logic [15:0] DELAY_LOAD = 16'(`POR_DELAY_CYCLES - 1);

	sleep_wake_pkg::power_state_t state_reg;
	sleep_wake_pkg::power_state_t state_next;
	logic [7:0] port_drive_config_reg;
	logic [6:0] stop_wake_control_reg;
	logic warm_start_flag_reg;
	logic [15:0] delay_cnt_reg;
	logic [7:0] reg_rdata_reg;
	logic cpu_clk_run_reg;
	logic osc_run_reg;
	logic comparator_power_reg;
	logic cpu_reset_hold_reg;
	logic restart_load_reg;
	logic restart_load_next;
	logic [15:0] restart_addr_reg;
	logic watchdog_run_reg;
	logic wake_hit;
	logic stop_recovery;
	logic wdt_outside_stop;
	logic sclk_run;
	logic timer_clock_run;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
		reg_hit = (addr == offset);
	endfunction

	wake_source_detect u_wake (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.src_sel(stop_wake_control_reg[`SWC_SRC_HI:`SWC_SRC_LO]),
		.level_high(stop_wake_control_reg[`SWC_LEVEL]),
		.port3_in(port3_in),
		.port2_in(port2_in),
		.wake_hit_reg(wake_hit)
	);

	assign sclk_run = (state_next == sleep_wake_pkg::st_run);
	assign timer_clock_run = (state_next != sleep_wake_pkg::st_stop);

	clock_enable_divider u_div (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.undivided_sel(stop_wake_control_reg[`SWC_UNDIV]),
		.div16_sel(stop_wake_control_reg[`SWC_DIV16]),
		.sclk_run(sclk_run),
		.timer_clock_run(timer_clock_run),
		.sclk_en_reg(sclk_en),
		.timer_clock_en_reg(timer_clock_en)
	);

	// a pin wake while stopped, the watchdog taking precedence
	assign stop_recovery = (state_reg == sleep_wake_pkg::st_stop) && wake_hit && !watchdog_timeout;
	assign wdt_outside_stop = watchdog_timeout && (state_reg != sleep_wake_pkg::st_stop);

	// power state sequencing
	always_comb begin
		state_next = state_reg;
		restart_load_next = 1'b0;
		unique case (state_reg)
			sleep_wake_pkg::st_run: begin
				if (watchdog_timeout) begin
					state_next = sleep_wake_pkg::st_delay;
				end else if (stop_exec) begin
					state_next = sleep_wake_pkg::st_stop; // RL3
				end else if (halt_exec) begin
					state_next = sleep_wake_pkg::st_halt; // RL18
				end
			end
			sleep_wake_pkg::st_halt: begin
				if (watchdog_timeout) begin
					state_next = sleep_wake_pkg::st_delay;
				end else if (irq_taken) begin
					state_next = sleep_wake_pkg::st_run; // RL1
				end
			end
			sleep_wake_pkg::st_stop: begin
				if (watchdog_timeout) begin
					state_next = sleep_wake_pkg::st_delay; // RL5
				end else if (wake_hit) begin
					if (stop_wake_control_reg[`SWC_DELAY]) begin
						state_next = sleep_wake_pkg::st_delay; // RL13
					end else begin
						state_next = sleep_wake_pkg::st_run; // RL20
						restart_load_next = 1'b1; // RL4
					end
				end
			end
			sleep_wake_pkg::st_delay: begin
				if (delay_cnt_reg == 16'h0000) begin
					state_next = sleep_wake_pkg::st_run;
					restart_load_next = 1'b1; // RL4
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= sleep_wake_pkg::st_delay;
		end else begin
			state_reg <= state_next;
		end
	end

	// reset delay count, reloaded on every entry
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			delay_cnt_reg <= DELAY_LOAD;
		end else if (state_next == sleep_wake_pkg::st_delay && state_reg != sleep_wake_pkg::st_delay) begin
			delay_cnt_reg <= DELAY_LOAD;
		end else if (state_reg == sleep_wake_pkg::st_delay && delay_cnt_reg != 16'h0000) begin
			delay_cnt_reg <= delay_cnt_reg - 16'h0001;
		end
	end

	// clock, power and restart controls
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cpu_clk_run_reg <= 1'b0;
			osc_run_reg <= 1'b1;
			comparator_power_reg <= 1'b1;
			cpu_reset_hold_reg <= 1'b1;
			restart_load_reg <= 1'b0;
		end else begin
			cpu_clk_run_reg <= (state_next == sleep_wake_pkg::st_run); // RL18
			osc_run_reg <= (state_next != sleep_wake_pkg::st_stop); // RL3
			comparator_power_reg <= (state_next != sleep_wake_pkg::st_stop); // RL3
			cpu_reset_hold_reg <= (state_next == sleep_wake_pkg::st_delay);
			restart_load_reg <= restart_load_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			restart_addr_reg <= `RESTART_ADDR;
		end else begin
			restart_addr_reg <= `RESTART_ADDR; // RL4
		end
	end

	// permanent rc watchdog cannot be stopped by any mode
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_run_reg <= 1'b1;
		end else begin
			watchdog_run_reg <= (watchdog_permanent && watchdog_rc_select) ||
				(state_next != sleep_wake_pkg::st_stop); // RL6
		end
	end

	// port drive configuration, write only
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			port_drive_config_reg <= `PDC_RESET;
		end else if (wdt_outside_stop) begin
			port_drive_config_reg <= `PDC_RESET;
		end else if (reg_wr && reg_hit(reg_addr, `PDC_OFFSET)) begin
			port_drive_config_reg <= reg_wdata; // RL7 RL8 RL9 RL10
		end
	end

	// stop wake control, low seven bits written by software
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stop_wake_control_reg <= 7'(`SWC_RESET);
		end else if (wdt_outside_stop) begin
			stop_wake_control_reg <= 7'(`SWC_RESET);
		end else if (stop_recovery || (watchdog_timeout && state_reg == sleep_wake_pkg::st_stop)) begin
			stop_wake_control_reg[`SWC_DIV16] <= 1'b0; // RL19 RL5
		end else if (reg_wr && reg_hit(reg_addr, `SWC_OFFSET)) begin
			stop_wake_control_reg <= reg_wdata[6:0]; // RL12 RL13 RL14 RL15 RL16
		end
	end

	// warm start flag: set on stop entry and recovery, cold after power-on or a watchdog reset outside stop
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			warm_start_flag_reg <= 1'b0; // RL11
		end else if (state_next == sleep_wake_pkg::st_stop && state_reg == sleep_wake_pkg::st_run) begin
			warm_start_flag_reg <= 1'b1; // RL21
		end else if (stop_recovery) begin
			warm_start_flag_reg <= 1'b1; // RL11
		end else if (wdt_outside_stop) begin
			warm_start_flag_reg <= 1'b0;
		end
	end

	// only the flag reads back, everything else reads zero
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_reg <= 8'h00;
		end else if (reg_rd && reg_hit(reg_addr, `SWC_OFFSET)) begin
			reg_rdata_reg <= {warm_start_flag_reg, 7'h00}; // RL11
		end else begin
			reg_rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign cpu_clk_run = cpu_clk_run_reg;
	assign osc_run = osc_run_reg;
	assign comparator_power = comparator_power_reg;
	assign cpu_reset_hold = cpu_reset_hold_reg;
	assign restart_load = restart_load_reg;
	assign restart_addr = restart_addr_reg;
	assign watchdog_run = watchdog_run_reg;
	assign comparator_route = port_drive_config_reg[`PDC_CMP_ROUTE];
	assign port0_push_pull = port_drive_config_reg[`PDC_P0_PUSH];
	assign port0_std_drive = port_drive_config_reg[`PDC_P0_STD];
	assign port2_std_drive = port_drive_config_reg[`PDC_P2_STD];
	assign port3_std_drive = port_drive_config_reg[`PDC_P3_STD];
	assign osc_std_drive = port_drive_config_reg[`PDC_OSC_STD];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	halt_hold_a: assert property ( // RL1
		state_reg == sleep_wake_pkg::st_halt && !irq_taken && !watchdog_timeout
		|=> state_reg == sleep_wake_pkg::st_halt)
		else $error("halt left without a taken interrupt");

	halt_resume_a: assert property ( // RL1
		state_reg == sleep_wake_pkg::st_halt && irq_taken && !watchdog_timeout
		|=> cpu_clk_run && !restart_load)
		else $error("halt exit did not resume in place");

	stop_power_a: assert property (state_reg == sleep_wake_pkg::st_stop |-> // RL3
		!osc_run && !comparator_power && !cpu_clk_run)
		else $error("clocks or comparators running in stop");

	fast_wake_a: assert property ( // RL4
		stop_recovery && !stop_wake_control_reg[`SWC_DELAY]
		|=> restart_load && restart_addr == 16'h000c)
		else $error("fast wake did not restart at 000c");

	wdt_stop_a: assert property ( // RL5
		state_reg == sleep_wake_pkg::st_stop && watchdog_timeout
		|=> cpu_reset_hold ##1 cpu_reset_hold)
		else $error("watchdog in stop skipped the reset delay");

	wdt_forever_a: assert property (watchdog_permanent && watchdog_rc_select |=> watchdog_run) // RL6
		else $error("permanent watchdog stopped");

	route_write_a: assert property ( // RL7
		reg_wr && reg_addr == 8'h00 && !watchdog_timeout
		|=> comparator_route == $past(reg_wdata[0]) && port0_push_pull == $past(reg_wdata[2]))
		else $error("drive register write not applied");

	drive_write_a: assert property ( // RL9
		reg_wr && reg_addr == 8'h00 && !watchdog_timeout
		|=> {port3_std_drive, port2_std_drive, port0_std_drive, osc_std_drive} ==
			{$past(reg_wdata[6]), $past(reg_wdata[5]), $past(reg_wdata[3]), $past(reg_wdata[7])})
		else $error("drive strength bits not applied");

	delay_wake_a: assert property (stop_recovery && stop_wake_control_reg[`SWC_DELAY] |=> // RL13
		cpu_reset_hold && !restart_load)
		else $error("delayed wake skipped the reset delay");

	div16_clear_a: assert property (stop_recovery |=> !stop_wake_control_reg[`SWC_DIV16]) // RL19
		else $error("prescaler select survived recovery");

	warm_entry_a: assert property ( // RL21
		state_reg == sleep_wake_pkg::st_run && stop_exec && !watchdog_timeout
		|=> warm_start_flag_reg ##1 warm_start_flag_reg)
		else $error("warm flag not set on stop entry");

	flag_read_a: assert property (reg_rd && reg_addr == 8'h0b |=> // RL11
		reg_rdata == {$past(warm_start_flag_reg), 7'h00})
		else $error("warm flag read back wrong");

	halt_only_cpu_a: assert property (state_reg == sleep_wake_pkg::st_halt |-> // RL18
		!cpu_clk_run && osc_run && comparator_power)
		else $error("halt stopped more than the cpu clock");

	halt_exit_c: cover property (state_reg == sleep_wake_pkg::st_halt && irq_taken);
	fast_wake_c: cover property (stop_recovery && !stop_wake_control_reg[`SWC_DELAY]);
	delay_wake_c: cover property (stop_recovery && stop_wake_control_reg[`SWC_DELAY]);
	wdt_stop_c: cover property (state_reg == sleep_wake_pkg::st_stop && watchdog_timeout);

endmodule

/* File: tb/sleep_wake_port_config_tb.sv */
// self-checking bench for the sleep/wake and port drive block
// assumes the design header defines offsets and the reset delay; bench drives all ports
`include "sleep_wake_cfg.svh"
module sleep_wake_port_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] d; logic [5:0] e;} drive_row_t;
	typedef struct {logic [7:0] swc; logic [3:0] p3i; logic [3:0] p3w; logic [7:0] p2i; logic [7:0] p2w;} stop_row_t;
	typedef struct {logic [7:0] swc; int s; int t;} clk_row_t;
	logic sys_clk, rstn, reg_wr, reg_rd, halt_exec, stop_exec, irq_taken, watchdog_timeout;
	logic watchdog_permanent, watchdog_rc_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, port2_in;
	logic [3:0] port3_in;
	logic cpu_clk_run, osc_run, comparator_power, cpu_reset_hold, restart_load, watchdog_run, sclk_en, timer_clock_en;
	logic comparator_route, port0_push_pull, port0_std_drive, port2_std_drive, port3_std_drive, osc_std_drive;
	logic [15:0] restart_addr;
	logic seen;
	int n_errors = 0;
	int n_compared = 0;
	int c, s, t;
	drive_row_t drive_rows [9] = '{'{8'h00, 6'h00}, '{8'hff, 6'h3f}, '{8'h01, 6'h01}, '{8'h04, 6'h02},
		'{8'h08, 6'h04}, '{8'h20, 6'h08}, '{8'h40, 6'h10}, '{8'h80, 6'h20}, '{8'hfe, 6'h3e}};
	stop_row_t stop_rows [9] = '{'{8'h45, 4'h0, 4'h1, 8'h00, 8'h00}, '{8'h48, 4'h0, 4'h2, 8'h00, 8'h00},
		'{8'h4c, 4'h0, 4'h4, 8'h00, 8'h00}, '{8'h50, 4'h0, 4'h8, 8'h00, 8'h00}, '{8'h54, 4'h0, 4'h0, 8'h00, 8'h80},
		'{8'h58, 4'h0, 4'h0, 8'hff, 8'hf0}, '{8'h5c, 4'h0, 4'h0, 8'hff, 8'h00}, '{8'h04, 4'hf, 4'he, 8'h00, 8'h00},
		'{8'h64, 4'h0, 4'h1, 8'h00, 8'h00}};
	clk_row_t clk_rows [4] = '{'{8'h20, 32, 32}, '{8'h22, 64, 64}, '{8'h21, 2, 2}, '{8'h23, 4, 4}};

	sleep_wake_port_config dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .stop_exec(stop_exec),
		.irq_taken(irq_taken), .watchdog_timeout(watchdog_timeout), .watchdog_permanent(watchdog_permanent),
		.watchdog_rc_select(watchdog_rc_select), .port3_in(port3_in), .port2_in(port2_in),
		.cpu_clk_run(cpu_clk_run), .osc_run(osc_run), .comparator_power(comparator_power),
		.cpu_reset_hold(cpu_reset_hold), .restart_load(restart_load), .restart_addr(restart_addr),
		.watchdog_run(watchdog_run), .sclk_en(sclk_en), .timer_clock_en(timer_clock_en), .comparator_route(comparator_route),
		.port0_push_pull(port0_push_pull), .port0_std_drive(port0_std_drive), .port2_std_drive(port2_std_drive),
		.port3_std_drive(port3_std_drive), .osc_std_drive(osc_std_drive));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic check_bit(string what, logic exp, logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0b, seen %0b", what, exp, got);
		end
	endtask

	task automatic check_val(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic check_count(string what, int exp, int got);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("unexpected %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask

	// the two mapped registers and the unmapped address 55 are written, the drive register stays untouched by the write to 55
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check_val("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask

	// 0 halt, 1 stop, 2 interrupt taken, 3 watchdog time-out
	// a sleep pulse stands for a sleep instruction issued after its no-op, pipeline empty
	task automatic pulse(int k);
		@(posedge sys_clk);
		halt_exec <= (k == 0);
		stop_exec <= (k == 1);
		irq_taken <= (k == 2);
		watchdog_timeout <= (k == 3);
		@(posedge sys_clk);
		{halt_exec, stop_exec, irq_taken, watchdog_timeout} <= 4'h0;
	endtask

	task automatic wait_restart(int bound, logic want_hold, output int n, output logic hit);
		hit = 1'b0;
		n = 0;
		while (!hit && n < bound) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (want_hold && n == 4)
				check_bit("cpu_reset_hold", 1'b1, cpu_reset_hold);
			if (restart_load === 1'b1)
				hit = 1'b1;
		end
	endtask

	task automatic ticks(int n, output int ns, output int nt);
		ns = 0;
		nt = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			ns += (sclk_en === 1'b1);
			nt += (timer_clock_en === 1'b1);
		end
	endtask

	task automatic check_delayed(int n, logic hit);
		check_bit("restart_load", 1'b1, hit);
		check_bit("delay length", 1'b1, n >= `POR_DELAY_CYCLES - 2 && n <= `POR_DELAY_CYCLES + 8);
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		check_val("drive outputs", 16'h003e, {10'h000, osc_std_drive, port3_std_drive, port2_std_drive,
			port0_std_drive, port0_push_pull, comparator_route});
		check_bit("cpu_reset_hold", 1'b1, cpu_reset_hold);
		@(posedge sys_clk);
		rstn <= 1'b1;
		wait_restart(400, 1'b1, c, seen);
		check_delayed(c, seen);
		@(posedge sys_clk);
		#1;
		check_bit("cpu_clk_run", 1'b1, cpu_clk_run);
	endtask

	task automatic complete_run();
		$display("errors %0d, comparisons %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#200us;
		n_errors++;
		complete_run();
	end

	initial begin
		{rstn, reg_wr, reg_rd, halt_exec, stop_exec, irq_taken, watchdog_timeout} = 7'h00;
		{watchdog_permanent, watchdog_rc_select} = 2'b00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		port3_in = 4'h0;
		port2_in = 8'h00;
		do_reset();
		rd(`SWC_OFFSET, 8'h00);
		rd(`PDC_OFFSET, 8'h00);
		rd(8'h55, 8'h00);
		foreach (drive_rows[i]) begin
			wr(`PDC_OFFSET, drive_rows[i].d);
			repeat (2) @(posedge sys_clk);
			#1;
			check_val("drive outputs", {10'h000, drive_rows[i].e}, {10'h000, osc_std_drive, port3_std_drive,
				port2_std_drive, port0_std_drive, port0_push_pull, comparator_route});
		end
		wr(8'h55, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1;
		check_bit("comparator_route", 1'b0, comparator_route);
		check_bit("port0_push_pull", 1'b1, port0_push_pull);
		wr(`SWC_OFFSET, 8'h80);
		rd(`SWC_OFFSET, 8'h00);
		foreach (clk_rows[i]) begin
			wr(`SWC_OFFSET, clk_rows[i].swc);
			repeat (4) @(posedge sys_clk);
			ticks(64, s, t);
			check_count("sclk ticks", clk_rows[i].s, s);
			check_count("timer_clock ticks", clk_rows[i].t, t);
		end
		wr(`SWC_OFFSET, 8'h20);
		pulse(0);
		#1;
		check_bit("cpu_clk_run", 1'b0, cpu_clk_run);
		check_bit("osc_run", 1'b1, osc_run);
		check_bit("comparator_power", 1'b1, comparator_power);
		ticks(64, s, t);
		check_count("sclk ticks", 0, s);
		check_count("timer_clock ticks", 32, t);
		pulse(1);
		#1;
		check_bit("osc_run", 1'b1, osc_run);
		pulse(2);
		#1;
		check_bit("cpu_clk_run", 1'b1, cpu_clk_run);
		wait_restart(8, 1'b0, c, seen);
		check_bit("restart_load", 1'b0, seen);
		foreach (stop_rows[i]) begin
			@(posedge sys_clk);
			port3_in <= stop_rows[i].p3i;
			port2_in <= stop_rows[i].p2i;
			wr(`SWC_OFFSET, stop_rows[i].swc);
			pulse(1);
			#1;
			check_bit("osc_run", 1'b0, osc_run);
			check_bit("comparator_power", 1'b0, comparator_power);
			check_bit("cpu_clk_run", 1'b0, cpu_clk_run);
			check_bit("watchdog_run", 1'b0, watchdog_run);
			rd(`SWC_OFFSET, 8'h80);
			wait_restart(8, 1'b0, c, seen);
			check_bit("early wake", 1'b0, seen);
			@(posedge sys_clk);
			port3_in <= stop_rows[i].p3w;
			port2_in <= stop_rows[i].p2w;
			wait_restart(400, stop_rows[i].swc[5], c, seen);
			if (stop_rows[i].swc[5])
				check_delayed(c, seen);
			else
				check_bit("fast wake", 1'b1, seen && c <= 4);
			check_val("restart_addr", 16'h000c, restart_addr);
			check_bit("osc_run", 1'b1, osc_run);
			repeat (8) @(posedge sys_clk);
			port3_in <= stop_rows[i].p3i;
			port2_in <= stop_rows[i].p2i;
			rd(`SWC_OFFSET, 8'h80);
			ticks(64, s, t);
			check_count("sclk ticks", 32, s);
		end
		wr(`PDC_OFFSET, 8'h00);
		port3_in <= 4'h0;
		port2_in <= 8'h00;
		wr(`SWC_OFFSET, 8'h00);
		watchdog_permanent <= 1'b1;
		watchdog_rc_select <= 1'b1;
		pulse(1);
		#1;
		check_bit("watchdog_run", 1'b1, watchdog_run);
		@(posedge sys_clk);
		port3_in <= 4'hf;
		port2_in <= 8'hff;
		wait_restart(16, 1'b0, c, seen);
		check_bit("source 000 wake", 1'b0, seen);
		pulse(3);
		wait_restart(400, 1'b1, c, seen);
		check_delayed(c, seen);
		watchdog_permanent <= 1'b0;
		watchdog_rc_select <= 1'b0;
		rd(`SWC_OFFSET, 8'h80);
		check_bit("port0_push_pull", 1'b0, port0_push_pull);
		do_reset();
		rd(`SWC_OFFSET, 8'h00);
		wr(`PDC_OFFSET, 8'h01);
		pulse(3);
		wait_restart(400, 1'b1, c, seen);
		check_delayed(c, seen);
		check_bit("comparator_route", 1'b0, comparator_route);
		complete_run();
	end
endmodule
